// ===== verilog/smc_regs.vh
// sleep mode controller constants: offsets, fields, modes, timing
// Functional notes
// - sleep only if arm bit set at instruction
// - select codes: idle, pdown, psave, standby, extstandby
// - interrupt wake: four-cycle stall plus start-up
// - wake leaves register file and memory intact
// - reset during sleep restarts from reset vector
// - idle stops only core and flash clocks
// - idle wakes on external and internal interrupts
// - power-down stops oscillator and generated clocks
// - power-down wakes on listed asynchronous sources only
// - power-down wake waits configured clock start-up
// - power-save behaves exactly as power-down
// - standby keeps oscillator, wakes in six cycles
// - extended standby equals standby with oscillator running
// - io clock idle only; oscillator off in pdown/psave
// - watchdog and usb wake interrupts wake always
// - sleep control bits 7-4 read zero
// - regulator off bit cleared by every reset
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
`define SMC_ADDR_SLEEP_CTRL   4'h0
`define SMC_ADDR_REG_CTRL     4'h4
`define SMC_ADDR_STATUS       4'h8
`define SMC_ARM_BIT           0
`define SMC_SEL_LSB           1
`define SMC_SEL_MSB           3
`define SMC_REGOFF_BIT        0
`define SMC_MODE_IDLE         3'h0
`define SMC_MODE_PDOWN        3'h2
`define SMC_MODE_PSAVE        3'h3
`define SMC_MODE_STANDBY      3'h6
`define SMC_MODE_EXTSTBY      3'h7
`define SMC_STALL_CYCLES      8'h04
`define SMC_STANDBY_CYCLES    8'h06
`define SMC_RESP_OKAY         2'h0
`define SMC_RESP_SLVERR       2'h2
`endif

// ===== verilog/smc_sleep_ctrl.v
// sleep mode controller: mode decode, clock gating, wake sequencing
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "smc_regs.vh"
module smc_sleep_ctrl (
   // clock and reset
   input  wire        CLOCK,
   input  wire        RESET,
   // axi4-lite write address
   input  wire [3:0]  AWADDR,
   input  wire        AWVALID,
   output reg         AWREADY,
   // axi4-lite write data
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output reg         WREADY,
   // axi4-lite write response
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   // axi4-lite read
   input  wire [3:0]  ARADDR,
   input  wire        ARVALID,
   output reg         ARREADY,
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // core side
   input  wire        SLEEP_INSTR,
   input  wire        EXT_CRYSTAL,
   input  wire [7:0]  STARTUP_CYCLES,
   // wake sources
   input  wire        EXT_IRQ_LOW_GROUP,
   input  wire        EXT_IRQ_HIGH_LEVEL,
   input  wire        PIN_CHANGE_IRQ,
   input  wire        TWI_ADDR_MATCH,
   input  wire        WDT_IRQ,
   input  wire        USB_WAKE_IRQ,
   input  wire        USB_SYNC_IRQ,
   input  wire        NVM_READY_IRQ,
   input  wire        OTHER_IO_IRQ,
   input  wire        EXT_IRQ_HIGH_EDGE,
   // clock gates and status
   output reg         CPU_CLK_EN,
   output reg         FLASH_CLK_EN,
   output reg         IO_CLK_EN,
   output reg         MAIN_OSC_EN,
   output reg         CPU_STALL,
   output reg         REGULATOR_OFF,
   output reg         ASLEEP
);

   localparam ST_RUN   = 4'b0001;
   localparam ST_SLEEP = 4'b0010;
   localparam ST_START = 4'b0100;
   localparam ST_STALL = 4'b1000;

   reg [3:0] state_q;
   reg [2:0] mode_q;
   reg [7:0] cnt_q;
   reg       arm_q;
   reg [2:0] sel_q;
   reg       aw_got_q;
   reg       w_got_q;
   reg [3:0] aw_addr_q;
   reg [7:0] w_data_q;
   reg       w_strb_q;
   reg [7:0] rd_d;
   reg [3:0] state_d;
   reg [2:0] mode_d;
   reg [7:0] cnt_d;
   reg       cpu_en_d;
   reg       io_en_d;
   reg       osc_en_d;
   reg       stall_d;
   reg       asleep_d;
   reg       arm_d;
   reg [2:0] sel_d;
   reg       regoff_d;
   reg [1:0] bresp_d;

   // bus handshake events
   wire wr_fire = aw_got_q && w_got_q && !BVALID;
   wire b_done  = BVALID && BREADY;
   wire ar_fire = ARVALID && ARREADY;
   wire r_done  = RVALID && RREADY;

   // reserved codes never sleep
   function valid_mode;
      input [2:0] m;
      begin
         valid_mode = (m == `SMC_MODE_IDLE) || (m == `SMC_MODE_PDOWN) ||
                      (m == `SMC_MODE_PSAVE) || (m == `SMC_MODE_STANDBY) ||
                      (m == `SMC_MODE_EXTSTBY);
      end
   endfunction

   // deep modes cut the oscillator
   function osc_stops;
      input [2:0] m;
      begin
         osc_stops = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE);
      end
   endfunction

   // only idle keeps the io clock
   function io_stops;
      input [2:0] m;
      begin
         io_stops = (m != `SMC_MODE_IDLE);
      end
   endfunction

   // offsets that answer okay
   function addr_mapped;
      input [3:0] a;
      begin
         addr_mapped = (a == `SMC_ADDR_SLEEP_CTRL) || (a == `SMC_ADDR_REG_CTRL) ||
                       (a == `SMC_ADDR_STATUS);
      end
   endfunction

   // stall and standby counters load one short since the zero cycle counts too
   function [7:0] count_down;
      input [7:0] c;
      begin
         count_down = c - 8'h01;
      end
   endfunction

   // standby variants need an external crystal to be entered
   wire mode_ok = valid_mode(sel_q) &&
                  (!sel_q[2] || EXT_CRYSTAL);
   wire enter = (state_q == ST_RUN) && SLEEP_INSTR && arm_q && mode_ok;

   wire deep_wake = EXT_IRQ_LOW_GROUP | EXT_IRQ_HIGH_LEVEL | PIN_CHANGE_IRQ |
                    TWI_ADDR_MATCH | WDT_IRQ | USB_WAKE_IRQ;
   wire idle_wake = deep_wake | EXT_IRQ_HIGH_EDGE | USB_SYNC_IRQ |
                    NVM_READY_IRQ | OTHER_IO_IRQ;
   wire wake = (mode_q == `SMC_MODE_IDLE) ? idle_wake : deep_wake;
   wire osc_off = osc_stops(mode_q);

   // sequencer next state
   always @* begin
      state_d = state_q;
      mode_d  = mode_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_RUN: begin
            if (enter) begin
               state_d = ST_SLEEP;
               mode_d  = sel_q;
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               if (mode_q == `SMC_MODE_IDLE) begin
                  state_d = ST_STALL;
                  cnt_d   = count_down(`SMC_STALL_CYCLES);
               end else if (osc_off) begin
                  state_d = ST_START;
                  cnt_d   = STARTUP_CYCLES;
               end else begin
                  state_d = ST_START;
                  cnt_d   = count_down(`SMC_STANDBY_CYCLES);
               end
            end
         end
         ST_START: begin
            if (cnt_q == 8'h00) begin
               state_d = ST_STALL;
               cnt_d   = count_down(`SMC_STALL_CYCLES);
            end else begin
               cnt_d = count_down(cnt_q);
            end
         end
         ST_STALL: begin
            if (cnt_q == 8'h00) begin
               state_d = ST_RUN;
            end else begin
               cnt_d = count_down(cnt_q);
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // sequencer; register file and memory are never touched here
   always @(posedge CLOCK) begin
      if (RESET) begin
         state_q <= ST_RUN;
         mode_q  <= `SMC_MODE_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         cnt_q   <= cnt_d;
      end
   end

   // gates look at entry too, so clocks stop on the edge that starts sleep
   always @* begin
      cpu_en_d = (state_q == ST_RUN) && !enter;
      io_en_d  = !((state_q == ST_SLEEP) && io_stops(mode_q)) &&
                 !(enter && io_stops(sel_q));
      osc_en_d = !((state_q == ST_SLEEP) && osc_off) &&
                 !(enter && osc_stops(sel_q));
      stall_d  = (state_q == ST_START) || (state_q == ST_STALL);
      asleep_d = (state_q == ST_SLEEP) || enter;
   end

   // clock gate outputs
   always @(posedge CLOCK) begin
      if (RESET) begin
         CPU_CLK_EN   <= 1'b1;
         FLASH_CLK_EN <= 1'b1;
         IO_CLK_EN    <= 1'b1;
         MAIN_OSC_EN  <= 1'b1;
         CPU_STALL    <= 1'b0;
         ASLEEP       <= 1'b0;
      end else begin
         CPU_CLK_EN   <= cpu_en_d;
         FLASH_CLK_EN <= cpu_en_d;
         IO_CLK_EN    <= io_en_d;
         MAIN_OSC_EN  <= osc_en_d;
         CPU_STALL    <= stall_d;
         ASLEEP       <= asleep_d;
      end
   end

   // register updates; a cleared byte strobe leaves everything as it was
   always @* begin
      arm_d    = arm_q;
      sel_d    = sel_q;
      regoff_d = REGULATOR_OFF;
      bresp_d  = `SMC_RESP_OKAY;
      if (wr_fire) begin
         if (!addr_mapped(aw_addr_q)) begin
            bresp_d = `SMC_RESP_SLVERR;
         end else if (w_strb_q) begin
            if (aw_addr_q == `SMC_ADDR_SLEEP_CTRL) begin
               arm_d = w_data_q[`SMC_ARM_BIT];
               sel_d = w_data_q[`SMC_SEL_MSB:`SMC_SEL_LSB];
            end
            if (aw_addr_q == `SMC_ADDR_REG_CTRL) begin
               regoff_d = w_data_q[`SMC_REGOFF_BIT];
            end
         end
      end
   end

   // axi4-lite write path: address and data taken in either order
   always @(posedge CLOCK) begin
      if (RESET) begin
         AWREADY   <= 1'b1;
         WREADY    <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         BVALID    <= 1'b0;
         BRESP     <= `SMC_RESP_OKAY;
         arm_q     <= 1'b0;
         sel_q     <= `SMC_MODE_IDLE;
         REGULATOR_OFF <= 1'b0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= AWADDR;
            AWREADY   <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_got_q  <= 1'b1;
            w_data_q <= WDATA[7:0];
            w_strb_q <= WSTRB[0];
            WREADY   <= 1'b0;
         end
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= bresp_d;
         end
         arm_q         <= arm_d;
         sel_q         <= sel_d;
         REGULATOR_OFF <= regoff_d;
         if (b_done) begin
            BVALID   <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            AWREADY  <= 1'b1;
            WREADY   <= 1'b1;
         end
      end
   end

   // read mux; upper control bits always zero
   always @* begin
      case (ARADDR)
         `SMC_ADDR_SLEEP_CTRL: rd_d = {4'h0, sel_q, arm_q};
         `SMC_ADDR_REG_CTRL:   rd_d = {7'h00, REGULATOR_OFF};
         `SMC_ADDR_STATUS:     rd_d = {state_q, 1'b0, mode_q};
         default:              rd_d = 8'h00;
      endcase
   end

   always @(posedge CLOCK) begin
      if (RESET) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h00000000;
         RRESP   <= `SMC_RESP_OKAY;
      end else begin
         if (ar_fire) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= {24'h000000, rd_d};
            RRESP   <= addr_mapped(ARADDR) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
         end else if (r_done) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

endmodule // smc_sleep_ctrl

// ===== verification/smc_sleep_ctrl_props.sv
// port-level assertions for the sleep mode controller
`timescale 1ns/10ps
module smc_sleep_ctrl_props (
   // clock and reset
   input wire        CLOCK,
   input wire        RESET,
   // watched ports
   input wire [31:0] RDATA,
   input wire        RVALID,
   input wire        SLEEP_INSTR,
   input wire        WDT_IRQ,
   input wire        USB_WAKE_IRQ,
   input wire        CPU_CLK_EN,
   input wire        FLASH_CLK_EN,
   input wire        IO_CLK_EN,
   input wire        MAIN_OSC_EN,
   input wire        CPU_STALL,
   input wire        REGULATOR_OFF,
   input wire        ASLEEP
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence s_enter;
      SLEEP_INSTR ##1 $rose(ASLEEP);
   endsequence
   // three quiet cycles leave slack for the enables to come back
   sequence s_run;
      (!ASLEEP && !CPU_STALL) [*3];
   endsequence
   a_arm_entry: assert property ($rose(ASLEEP) |-> $past(SLEEP_INSTR))
      else $error("sleep entered without instruction");
   a_core_gated: assert property (s_enter |-> !CPU_CLK_EN && !FLASH_CLK_EN)
      else $error("core clocks run in sleep");
   a_osc_idle: assert property (ASLEEP && IO_CLK_EN |-> MAIN_OSC_EN)
      else $error("oscillator off with io clock running");
   a_regoff_clear: assert property (disable iff (1'b0) RESET |=> !REGULATOR_OFF)
      else $error("regulator off survives reset");
   a_stall_bound: assert property ($rose(CPU_STALL) |-> ##[1:300] !CPU_STALL)
      else $error("stall never ends");
   a_wake_stall: assert property ($fell(ASLEEP) |-> ##[0:1] CPU_STALL)
      else $error("wake without stall");
   a_wake_always: assert property (ASLEEP && (WDT_IRQ || USB_WAKE_IRQ) |-> ##[1:300] !ASLEEP)
      else $error("watchdog or usb wake ignored");
   a_rd_upper: assert property (RVALID |-> RDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_run_clocks: assert property (s_run |-> CPU_CLK_EN && IO_CLK_EN && MAIN_OSC_EN)
      else $error("clocks off while running");
endmodule // smc_sleep_ctrl_props

// ===== verification/smc_sleep_ctrl_bench.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/10ps
`include "smc_regs.vh"
module smc_sleep_ctrl_bench;
   reg         clk, rst, awv, wv, bry, arv, rry, slp, xtal;
   reg  [3:0]  awa, ara;
   reg  [31:0] wd, rnd;
   reg  [7:0]  sup;
   reg  [3:0]  strb;
   reg  [9:0]  irq;
   wire        awr, wrd, brv, arr, rv, ce, fe, ie, oe, st, ro, asl;
   wire [1:0]  br, rr;
   wire [31:0] rdt;
   integer     n_fail, checks_done, i, n, e;
   reg  [33:0] q[$];
   smc_sleep_ctrl dut (.CLOCK(clk), .RESET(rst), .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
      .WDATA(wd), .WSTRB(strb), .WVALID(wv), .WREADY(wrd), .BRESP(br), .BVALID(brv),
      .BREADY(bry), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdt), .RRESP(rr),
      .RVALID(rv), .RREADY(rry), .SLEEP_INSTR(slp), .EXT_CRYSTAL(xtal), .STARTUP_CYCLES(sup),
      .EXT_IRQ_LOW_GROUP(irq[0]), .EXT_IRQ_HIGH_LEVEL(irq[1]), .PIN_CHANGE_IRQ(irq[2]),
      .TWI_ADDR_MATCH(irq[3]), .WDT_IRQ(irq[4]), .USB_WAKE_IRQ(irq[5]),
      .USB_SYNC_IRQ(irq[6]), .NVM_READY_IRQ(irq[7]), .OTHER_IO_IRQ(irq[8]),
      .EXT_IRQ_HIGH_EDGE(irq[9]), .CPU_CLK_EN(ce), .FLASH_CLK_EN(fe), .IO_CLK_EN(ie),
      .MAIN_OSC_EN(oe), .CPU_STALL(st), .REGULATOR_OFF(ro), .ASLEEP(asl));
   function [31:0] xs(input [31:0] v);
      begin
         xs = v ^ (v << 13);
         xs = xs ^ (xs >> 17);
         xs = xs ^ (xs << 5);
      end
   endfunction
   task summarize;
      begin
         $display("checks %0d failures %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [33:0] got, input [33:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // values read right after an edge are the sampled ones
   task wr(input [3:0] a, input [7:0] d, input [1:0] r);
      begin
         @(posedge clk);
         awa <= a;
         wd <= {24'h0, d};
         awv <= 1'b1;
         wv <= 1'b1;
         bry <= 1'b1;
         q.push_back({r, 32'h0});
         do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
         end while (!(awr || !awv) || !(wrd || !wv));
         while (!brv) @(posedge clk);
         bry <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [33:0] x);
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'b1;
         rry <= 1'b1;
         q.push_back(x);
         do @(posedge clk); while (!arr);
         arv <= 1'b0;
         while (!rv) @(posedge clk);
         rry <= 1'b0;
      end
   endtask
   always @(posedge clk) begin
      if (rv && rry) chk({rr, rdt}, q.pop_front());
      if (brv && bry) chk({br, 32'h0}, q.pop_front());
   end
   task go_sleep;
      begin
         @(posedge clk);
         slp <= 1'b1;
         @(posedge clk);
         slp <= 1'b0;
         @(posedge clk);
      end
   endtask
   task nap(input [2:0] m, input arm, input x);
      begin
         rnd = xs(rnd);
         xtal <= x;
         sup <= 8'h08 + rnd[3:0];
         wr(`SMC_ADDR_SLEEP_CTRL, {4'h0, m, arm}, `SMC_RESP_OKAY);
         go_sleep;
         chk(asl, arm && (m == 0 || m == 2 || m == 3 || (m[2:1] == 2'h3 && x)));
         if (asl === 1'b1) begin
            chk({ie, oe}, {m == 0, m != 2 && m != 3});
            if (m != 0) begin
               irq <= 10'h040 << (rnd[7:4] % 4);
               repeat (12) @(posedge clk);
               chk(asl, 1'b1);
            end
            irq <= 10'h001 << (rnd[15:8] % (m == 0 ? 10 : 6));
            e = 4 + (m == 0 ? 0 : (m[2] ? 6 : sup + 1));
            n = 0;
            do begin @(posedge clk); n = n + 1; end while (!st);
            do begin @(posedge clk); n = n + 1; end while (st);
            chk(n >= e - 1 && n <= e + 3, 1'b1);
            irq <= 10'h0;
            repeat (3) @(posedge clk);
            chk({ce, fe, ie, oe}, 4'hf);
            wr(`SMC_ADDR_SLEEP_CTRL, {4'h0, m, 1'b0}, `SMC_RESP_OKAY);
         end
      end
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      n_fail = n_fail + 1;
      summarize;
   end
   initial begin
      {rst, awv, wv, bry, arv, rry, slp, xtal} = 8'h81;
      {awa, ara, wd, sup, irq} = 0;
      strb = 4'hf;
      n_fail = 0;
      checks_done = 0;
      rnd = 32'h506aeeb0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(`SMC_ADDR_SLEEP_CTRL, 34'h0);
      rd(`SMC_ADDR_REG_CTRL, 34'h0);
      rd(`SMC_ADDR_STATUS, 34'h10);
      rd(4'hc, {`SMC_RESP_SLVERR, 32'h0});
      wr(`SMC_ADDR_REG_CTRL, 8'h01, `SMC_RESP_OKAY);
      chk(ro, 1'b1);
      strb <= 4'h0;
      wr(`SMC_ADDR_REG_CTRL, 8'h00, `SMC_RESP_OKAY);
      chk(ro, 1'b1);
      strb <= 4'hf;
      wr(4'hc, 8'h00, `SMC_RESP_SLVERR);
      chk(ro, 1'b1);
      rnd = xs(rnd);
      wr(`SMC_ADDR_SLEEP_CTRL, rnd[7:0], `SMC_RESP_OKAY);
      rd(`SMC_ADDR_SLEEP_CTRL, {30'h0, rnd[3:0]});
      for (i = 0; i < 32; i = i + 1) nap(i[2:0], i > 7, i[4]);
      // reset mid-sleep must bring clocks back and clear the regulator bit
      wr(`SMC_ADDR_SLEEP_CTRL, 8'h05, `SMC_RESP_OKAY);
      go_sleep;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({asl, ro, ce, oe}, 4'h3);
      summarize;
   end
endmodule // smc_sleep_ctrl_bench
bind smc_sleep_ctrl smc_sleep_ctrl_props u_props (.CLOCK, .RESET, .RDATA, .RVALID,
   .SLEEP_INSTR, .WDT_IRQ, .USB_WAKE_IRQ, .CPU_CLK_EN, .FLASH_CLK_EN, .IO_CLK_EN,
   .MAIN_OSC_EN, .CPU_STALL, .REGULATOR_OFF, .ASLEEP);
